// File: hdl/cpu_address_generation.sv
// address generation and interrupt status of the cpu core
//
// Behaviour
// - maskable interrupts granted only while global enable set; nmi always
// - four-bit priority loaded on entry, software writable
// - level 15 admits only traps and nmi
// - reset clears enable, priority becomes zero
// - instruction offset 16-bit, unmapped, indirect change
// - offset advances on fetch, branches; resets zero
// - code segment low 8 bits, upper reserved
// - segmented code address is segment over offset
// - segmented code access drives segment pins
// - non-segmented code stays in segment zero
// - code segment read-only to data writes
// - interrupt or trap clears code segment
// - four page registers, 10-bit page, reserved upper
// - long accesses translated except override and pec
// - top two bits pick page over 14 bits
// - reset gives identity map of pages 3..0
// - non-segmented mode uses two page bits
// - segmented data access drives page bits out
// - page write lags one instruction for operands
module cpu_address_generation
  import cpu_addr_pkg::*;
#(
  parameter int SEG_PINS = 8
)(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // memory mode
  input  wire logic                        i_segmented,
  input  wire logic [SWID_W-1:0]           i_segment_width_setting,
  // instruction flow
  input  wire logic                        i_instr_start,
  input  wire logic                        i_fetch,
  input  wire logic [IP_W-1:0]             i_fetch_len,
  input  wire logic                        i_branch,
  input  wire logic [IP_W-1:0]             i_branch_ofs,
  input  wire logic                        i_far_jump,
  input  wire cpu_addr_pkg::far_target_t   i_far_target,
  input  wire logic                        i_far_pop,
  input  wire cpu_addr_pkg::far_target_t   i_pop_target,
  input  wire logic                        i_irq_accept,
  input  wire logic                        i_trap_exec,
  input  wire logic [IP_W-1:0]             i_vector_ofs,
  input  wire logic [LVL_W-1:0]            i_accept_level,
  // special function register port
  input  wire logic                        i_sfr_wr,
  input  wire cpu_addr_pkg::sfr_sel_t      i_sfr_sel,
  input  wire logic [SFR_W-1:0]            i_sfr_wdata,
  output logic      [SFR_W-1:0]            o_sfr_rdata,
  // interrupt arbitration
  input  wire logic                        i_irq_req,
  input  wire logic [LVL_W-1:0]            i_irq_req_level,
  input  wire logic                        i_nmi_req,
  output logic                             o_irq_grant,
  output logic                             o_global_irq_enable,
  output logic      [LVL_W-1:0]            o_cpu_priority_level,
  // data access
  input  wire logic                        i_data_valid,
  input  wire cpu_addr_pkg::data_req_t     i_data_req,
  output logic                             o_data_valid,
  output logic      [PADDR_W-1:0]          o_data_addr,
  // code access and segment pins
  input  wire logic                        i_code_ext,
  output logic      [PADDR_W-1:0]          o_code_addr,
  output logic      [SEG_PINS-1:0]         o_seg_pins
);
  import cpu_addr_pkg::*;

  // refuse pin counts the segment field cannot feed
  if (SEG_PINS < 1 || SEG_PINS > SEG_W) begin : g_bad_pins
    $error("SEG_PINS must lie between 1 and the segment width");
  end

  logic                             global_irq_enable;
  logic [LVL_W-1:0]                 cpu_priority_level;
  logic [IP_W-1:0]                  instruction_offset;
  logic [SEG_W-1:0]                 code_segment_select;
  logic [NUM_DPP-1:0][PAGE_W-1:0]   data_page_select;
  logic [NUM_DPP-1:0][PAGE_W-1:0]   dpp_stage;
  logic [NUM_DPP-1:0][PAGE_W-1:0]   dpp_eff;
  logic [PADDR_W-1:0]               next_code_addr;
  logic [PADDR_W-1:0]               next_data_addr;
  logic [PAGE_W-1:0]                data_page;
  logic                             accept;
  logic                             maskable_ok;
  logic [SEG_W-1:0]                 pin_mask;

  assign accept      = i_irq_accept || i_trap_exec;
  assign pin_mask    = seg_mask(i_segment_width_setting);
  // a maskable request wins only above current level
  assign maskable_ok = global_irq_enable && i_irq_req
                       && (i_irq_req_level > cpu_priority_level);

  // global enable and priority level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      global_irq_enable  <= IEN_RESET;
      cpu_priority_level <= LVL_RESET;
    end else if (i_irq_accept) begin
      cpu_priority_level <= i_accept_level;
    end else if (i_sfr_wr && i_sfr_sel == SFR_PSW) begin
      global_irq_enable  <= i_sfr_wdata[IEN_BIT];
      cpu_priority_level <= i_sfr_wdata[LVL_LSB +: LVL_W];
    end
  end

  // interrupt grant to the controller
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_grant <= 1'b0;
    end else begin
      o_irq_grant <= i_nmi_req || maskable_ok;
    end
  end

  // instruction offset: no sfr path reaches it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      instruction_offset <= IP_RESET;
    end else if (accept) begin
      instruction_offset <= i_vector_ofs;
    end else if (i_far_pop) begin
      instruction_offset <= i_pop_target.ofs;
    end else if (i_far_jump) begin
      instruction_offset <= i_far_target.ofs;
    end else if (i_branch) begin
      instruction_offset <= i_branch_ofs;
    end else if (i_fetch) begin
      instruction_offset <= instruction_offset + i_fetch_len;
    end
  end

  // code segment: far ops and pops only, cleared on accept
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      code_segment_select <= CSP_RESET;
    end else if (accept) begin
      code_segment_select <= CSP_RESET;
    end else if (i_far_pop) begin
      code_segment_select <= i_pop_target.seg;
    end else if (i_far_jump) begin
      code_segment_select <= i_far_target.seg;
    end
  end

  // data page registers written through the sfr port
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_page_select <= DPP_RESET;
    end else if (i_sfr_wr && i_sfr_sel <= SFR_DATA_PAGE_SELECT_3) begin
      data_page_select[i_sfr_sel[1:0]] <= i_sfr_wdata[PAGE_W-1:0];
    end
  end

  // operand pages take a write at the second instruction boundary after it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dpp_stage <= DPP_RESET;
      dpp_eff   <= DPP_RESET;
    end else if (i_instr_start) begin
      dpp_stage <= data_page_select;
      dpp_eff   <= dpp_stage;
    end
  end

  // address formers
  code_addr_former u_code (
    .i_ofs       (instruction_offset),
    .i_seg       (code_segment_select),
    .i_segmented (i_segmented),
    .o_addr      (next_code_addr)
  );

  data_page_xlate u_data (
    .i_dpp       (dpp_eff),
    .i_req       (i_data_req),
    .i_segmented (i_segmented),
    .o_addr      (next_data_addr),
    .o_page      (data_page)
  );

  // registered code address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_code_addr <= '0;
    end else begin
      o_code_addr <= next_code_addr;
    end
  end

  // registered data address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data_valid <= 1'b0;
      o_data_addr  <= '0;
    end else begin
      o_data_valid <= i_data_valid;
      if (i_data_valid) begin
        o_data_addr <= next_data_addr;
      end
    end
  end

  // segment pins: data access wins over code access
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_segmented) begin
      o_seg_pins <= '0;
    end else if (i_data_valid && i_data_req.external) begin
      o_seg_pins <= SEG_PINS'(next_data_addr[PADDR_W-1 -: SEG_W] & pin_mask);
    end else if (i_code_ext) begin
      o_seg_pins <= SEG_PINS'(code_segment_select & pin_mask);
    end
  end

  // status and sfr read-back; offset is not readable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_global_irq_enable  <= IEN_RESET;
      o_cpu_priority_level <= LVL_RESET;
      o_sfr_rdata          <= '0;
    end else begin
      o_global_irq_enable  <= global_irq_enable;
      o_cpu_priority_level <= cpu_priority_level;
      unique case (i_sfr_sel)
        SFR_DATA_PAGE_SELECT_0, SFR_DATA_PAGE_SELECT_1, SFR_DATA_PAGE_SELECT_2, SFR_DATA_PAGE_SELECT_3: begin
          o_sfr_rdata <= SFR_W'(data_page_select[i_sfr_sel[1:0]]);
        end
        SFR_CSP: begin
          o_sfr_rdata <= SFR_W'(code_segment_select);
        end
        SFR_PSW: begin
          o_sfr_rdata <= '0;
          o_sfr_rdata[IEN_BIT] <= global_irq_enable;
          o_sfr_rdata[LVL_LSB +: LVL_W] <= cpu_priority_level;
        end
        default: begin
          o_sfr_rdata <= '0;
        end
      endcase
    end
  end

  // checks kept next to the logic
  sequence s_accept;
    i_irq_accept || i_trap_exec;
  endsequence

  sequence s_plain_fetch;
    i_fetch && !accept && !i_far_pop && !i_far_jump && !i_branch;
  endsequence

  // write while both copies agree, next instruction starts right after
  sequence s_data_page_select_0_write;
    i_sfr_wr && i_sfr_sel == SFR_DATA_PAGE_SELECT_0 && !i_instr_start && dpp_stage[0] == dpp_eff[0]
    ##1 i_instr_start;
  endsequence

  sequence s_ext_data;
    i_data_valid && i_data_req.external && i_segmented
    && !i_data_req.extended && !i_data_req.peripheral_event_transfer;
  endsequence

  sequence s_ext_code;
    i_segmented && i_code_ext && !(i_data_valid && i_data_req.external);
  endsequence

  sequence s_paged_data;
    i_data_valid && i_segmented && !i_data_req.extended && !i_data_req.peripheral_event_transfer;
  endsequence

  sequence s_no_flow;
    !accept && !i_far_pop && !i_far_jump && !i_branch && !i_fetch;
  endsequence

  a_reset_state: assert property (@(posedge i_clk)
    i_rst |=> !global_irq_enable && cpu_priority_level == 4'h0
              && data_page_select == DPP_RESET)
    else $error("reset left enable, level or pages wrong");

  a_ien_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
    (!global_irq_enable && !i_nmi_req) |=> !o_irq_grant)
    else $error("grant while interrupts disabled");

  a_level_top: assert property (@(posedge i_clk) disable iff (i_rst)
    (cpu_priority_level == 4'hF && !i_nmi_req) |=> !o_irq_grant)
    else $error("maskable grant at top level");

  a_entry_level: assert property (@(posedge i_clk) disable iff (i_rst)
    i_irq_accept |=> cpu_priority_level == $past(i_accept_level)
                     ##1 o_cpu_priority_level == $past(i_accept_level, 2))
    else $error("level not loaded on entry");

  a_csp_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
    s_accept |=> code_segment_select == 8'h00)
    else $error("segment not cleared on accept");

  a_csp_no_sfr: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sfr_wr && i_sfr_sel == SFR_CSP && !accept && !i_far_pop && !i_far_jump)
    |=> $stable(code_segment_select))
    else $error("data write changed code segment");

  a_ip_fetch: assert property (@(posedge i_clk) disable iff (i_rst)
    s_plain_fetch |=> instruction_offset == $past(instruction_offset) + $past(i_fetch_len))
    else $error("offset did not advance on fetch");

  a_code_form: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_code_addr == ($past(i_segmented)
      ? {$past(code_segment_select), $past(instruction_offset)}
      : {8'h00, $past(instruction_offset)}))
    else $error("code address badly formed");

  a_data_nonseg: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_data_valid && !i_segmented && !i_data_req.extended && !i_data_req.peripheral_event_transfer)
    |=> o_data_addr[23:16] == 8'h00 && o_data_valid)
    else $error("non-segmented data used high page bits");

  a_data_lag: assert property (@(posedge i_clk) disable iff (i_rst)
    s_data_page_select_0_write |=> dpp_eff[0] == $past(dpp_eff[0], 2))
    else $error("page write applied to next instruction");

  a_data_pins: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ext_data |=> o_seg_pins
      == SEG_PINS'($past(dpp_eff[i_data_req.addr16[IP_W-1 -: 2]][PAGE_W-1 -: SEG_W] & pin_mask)))
    else $error("segment pins wrong on external data access");

  a_code_pins: assert property (@(posedge i_clk) disable iff (i_rst)
    s_ext_code |=> o_seg_pins == SEG_PINS'($past(code_segment_select & pin_mask)))
    else $error("segment pins wrong on external code access");

  a_flat_pins: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_segmented |=> o_seg_pins == '0)
    else $error("segment pins driven in non-segmented mode");

  a_page_concat: assert property (@(posedge i_clk) disable iff (i_rst)
    s_paged_data |=> o_data_addr == {$past(dpp_eff[i_data_req.addr16[IP_W-1 -: 2]]),
                                     $past(i_data_req.addr16[OFS_W-1:0])})
    else $error("paged data address badly formed");

  a_data_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_data_valid && (i_data_req.extended || i_data_req.peripheral_event_transfer))
    |=> o_data_addr == $past(i_data_req.addr24))
    else $error("override or pec access was translated");

  a_ip_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    s_no_flow |=> $stable(instruction_offset))
    else $error("offset changed without a flow event");

endmodule

// File: hdl/cpu_addr_pkg.sv
// constants, field layouts and carriers for cpu address generation
package cpu_addr_pkg;

  // word and field widths
  localparam int IP_W    = 16;
  localparam int SEG_W   = 8;
  localparam int PAGE_W  = 10;
  localparam int OFS_W   = 14;
  localparam int PADDR_W = 24;
  localparam int NUM_DPP = 4;
  localparam int LVL_W   = 4;
  localparam int SWID_W  = 4;
  localparam int SFR_W   = 16;

  // reset values and the top priority level
  localparam logic [IP_W-1:0]   IP_RESET  = 16'h0000;
  localparam logic [SEG_W-1:0]  CSP_RESET = 8'h00;
  localparam logic [LVL_W-1:0]  LVL_RESET = 4'h0;
  localparam logic [LVL_W-1:0]  LVL_MAX   = 4'hF;
  localparam logic              IEN_RESET = 1'b0;
  localparam logic [PAGE_W-1:0] DATA_PAGE_SELECT_0_RESET = 10'h000;
  localparam logic [PAGE_W-1:0] DATA_PAGE_SELECT_1_RESET = 10'h001;
  localparam logic [PAGE_W-1:0] DATA_PAGE_SELECT_2_RESET = 10'h002;
  localparam logic [PAGE_W-1:0] DATA_PAGE_SELECT_3_RESET = 10'h003;
  localparam logic [NUM_DPP-1:0][PAGE_W-1:0] DPP_RESET =
    {DATA_PAGE_SELECT_3_RESET, DATA_PAGE_SELECT_2_RESET, DATA_PAGE_SELECT_1_RESET, DATA_PAGE_SELECT_0_RESET};

  // field positions of the status word on the sfr port, and non-segmented page width
  localparam int IEN_BIT  = 11;
  localparam int LVL_LSB  = 12;
  localparam int NSEG_PG  = 2;  // page bits kept in non-segmented mode

  // sfr selector seen by the instruction unit
  typedef enum logic [2:0] {
    SFR_DATA_PAGE_SELECT_0 = 3'h0,
    SFR_DATA_PAGE_SELECT_1 = 3'h1,
    SFR_DATA_PAGE_SELECT_2 = 3'h2,
    SFR_DATA_PAGE_SELECT_3 = 3'h3,
    SFR_CSP  = 3'h4,
    SFR_PSW  = 3'h5
  } sfr_sel_t;

  // far target: segment plus offset
  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic [IP_W-1:0]  ofs;
  } far_target_t;

  // one data access request
  typedef struct packed {
    logic [IP_W-1:0]    addr16;
    logic [PADDR_W-1:0] addr24;   // used when translation is bypassed
    logic               extended; // extended-addressing override
    logic               peripheral_event_transfer;      // peripheral_event_transfer
    logic               external;
  } data_req_t;

  // mask of the lowest w segment pins
  function automatic logic [SEG_W-1:0] seg_mask(input logic [SWID_W-1:0] w);
    logic [SEG_W:0] m;
    m = '0;
    for (int b = 0; b < SEG_W; b++) begin
      if (b < int'(w)) begin
        m[b] = 1'b1;
      end
    end
    return m[SEG_W-1:0];
  endfunction

endpackage

// File: hdl/code_addr_former.sv
// code address former: offset extended by segment number
module code_addr_former
  import cpu_addr_pkg::*;
(
  // inputs
  input  wire logic [IP_W-1:0]    i_ofs,
  input  wire logic [SEG_W-1:0]   i_seg,
  input  wire logic               i_segmented,
  // result
  output logic      [PADDR_W-1:0] o_addr
);
  // segment forced to zero when segmentation is off
  always_comb begin
    if (i_segmented) begin
      o_addr = {i_seg, i_ofs};
    end else begin
      o_addr = {CSP_RESET, i_ofs};
    end
  end
endmodule

// File: hdl/data_page_xlate.sv
// data page translation of a long 16-bit address
module data_page_xlate
  import cpu_addr_pkg::*;
(
  // inputs
  input  wire logic [NUM_DPP-1:0][PAGE_W-1:0] i_dpp,
  input  wire data_req_t                      i_req,
  input  wire logic                           i_segmented,
  // results
  output logic      [PADDR_W-1:0]             o_addr,
  output logic      [PAGE_W-1:0]              o_page
);
  logic [1:0] sel;

  assign sel = i_req.addr16[IP_W-1 -: 2];

  // page above offset; bypassed for override and pec moves
  always_comb begin
    o_page = i_dpp[sel];
    if (!i_segmented) begin
      o_page = {{(PAGE_W-NSEG_PG){1'b0}}, i_dpp[sel][NSEG_PG-1:0]};
    end
    if (i_req.extended || i_req.peripheral_event_transfer) begin
      o_addr = i_req.addr24;
    end else begin
      o_addr = {o_page, i_req.addr16[OFS_W-1:0]};
    end
  end
endmodule

// File: test/exec_unit_model.sv
// instruction unit model: instruction starts and fetches
module exec_unit_model (
  // clock and control
  input  wire logic        i_clk,
  input  wire logic        i_run,
  // instruction flow
  output logic             o_instr_start,
  output logic             o_fetch,
  output logic [15:0]      o_fetch_len,
  output logic [15:0]      o_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] len;

  // idle at time zero
  initial begin
    o_instr_start = 1'b0;
    o_fetch       = 1'b0;
    o_fetch_len   = 16'h0000;
    o_bytes       = 16'h0000;
  end

  // start pulse, then one fetch of 2 to 6 bytes; total kept for the bench
  always @(posedge i_clk) begin
    len = 16'(2 * $urandom_range(1, 3));
    o_instr_start <= i_run && !o_instr_start;
    o_fetch       <= o_instr_start;
    o_fetch_len   <= o_instr_start ? len : ~o_fetch_len;  // junk outside a fetch
    if (o_instr_start) begin
      o_bytes <= o_bytes + len;
    end
  end
endmodule

// File: test/cpu_address_generation_bench.sv
// self-checking bench for cpu address generation
module cpu_address_generation_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_addr_pkg::*;

  logic            i_clk, i_rst, i_segmented, i_instr_start, i_fetch, i_branch;
  logic            i_far_jump, i_far_pop, i_irq_accept, i_trap_exec, i_sfr_wr;
  logic            i_irq_req, i_nmi_req, i_data_valid, i_code_ext, o_irq_grant;
  logic            o_global_irq_enable, o_data_valid, tb_start, m_start, run;
  logic [3:0]      i_segment_width_setting, i_accept_level, i_irq_req_level;
  logic [3:0]      o_cpu_priority_level;
  logic [15:0]     i_fetch_len, i_branch_ofs, i_vector_ofs, i_sfr_wdata, o_sfr_rdata;
  logic [15:0]     bytes, b0, v;
  logic [23:0]     o_data_addr, o_code_addr;
  logic [7:0]      o_seg_pins;
  logic [3:0][9:0] pg;
  far_target_t     i_far_target, i_pop_target;
  sfr_sel_t        i_sfr_sel;
  data_req_t       i_data_req, r;
  int              err_count, num_checks, k;

  assign i_instr_start = m_start | tb_start;

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  exec_unit_model model (
    .i_clk, .i_run(run), .o_instr_start(m_start), .o_fetch(i_fetch),
    .o_fetch_len(i_fetch_len), .o_bytes(bytes)
  );

  cpu_address_generation #(.SEG_PINS(8)) dut (
    .i_clk, .i_rst, .i_segmented, .i_segment_width_setting, .i_instr_start, .i_fetch,
    .i_fetch_len, .i_branch, .i_branch_ofs, .i_far_jump, .i_far_target, .i_far_pop,
    .i_pop_target, .i_irq_accept, .i_trap_exec, .i_vector_ofs, .i_accept_level,
    .i_sfr_wr, .i_sfr_sel, .i_sfr_wdata, .o_sfr_rdata, .i_irq_req, .i_irq_req_level,
    .i_nmi_req, .o_irq_grant, .o_global_irq_enable, .o_cpu_priority_level,
    .i_data_valid, .i_data_req, .o_data_valid, .o_data_addr, .i_code_ext, .o_code_addr,
    .o_seg_pins
  );

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // mask of the lowest w segment pins
  function automatic logic [7:0] msk(input logic [3:0] w);
    return 8'((16'h0001 << w) - 16'h0001);
  endfunction

  task automatic wr(input sfr_sel_t s, input logic [15:0] d);
    tick(1);
    i_sfr_sel <= s;
    {i_sfr_wr, i_sfr_wdata} <= {1'b1, d};
    tick(1);
    i_sfr_wr <= 1'b0;
  endtask

  // registered read; page registers compared on their 10 live bits
  task automatic rd(input sfr_sel_t s, input logic [15:0] exp, input string what);
    tick(1);
    i_sfr_sel <= s;
    tick(2);
    #1;
    check(what, 24'(exp), 24'((s < SFR_CSP) ? (o_sfr_rdata & 16'h03FF) : o_sfr_rdata));
  endtask

  task automatic step;
    tick(1);
    tb_start <= 1'b1;
    tick(1);
    tb_start <= 1'b0;
  endtask

  // one control-flow pulse, code address checked once it has landed
  task automatic ctl(input int c, input far_target_t t, input logic [23:0] e, input string w);
    tick(1);
    {i_far_jump, i_far_pop, i_branch, i_irq_accept, i_trap_exec} <= 5'b10000 >> c;
    {i_far_target, i_pop_target, i_branch_ofs, i_vector_ofs} <= {t, t, t.ofs, t.ofs};
    tick(1);
    {i_far_jump, i_far_pop, i_branch, i_irq_accept, i_trap_exec} <= 5'b00000;
    tick(2);
    #1;
    check(w, e, o_code_addr);
  endtask

  // one data access against the bench's own page table
  task automatic dacc(input data_req_t q, input logic sg, input logic [3:0] w);
    logic [9:0]  p;
    logic [23:0] e;
    p = pg[q.addr16[15:14]];
    if (!sg) begin
      p = {8'h00, p[1:0]};
    end
    e = (q.extended | q.peripheral_event_transfer) ? q.addr24 : {p, q.addr16[13:0]};
    tick(1);
    {i_data_valid, i_data_req, i_segmented, i_segment_width_setting} <= {1'b1, q, sg, w};
    tick(1);
    i_data_valid <= 1'b0;
    #1;
    check("data addr", e, o_data_addr);
    check("data valid", 24'h000001, 24'(o_data_valid));
    if (q.external && !q.extended && !q.peripheral_event_transfer) begin
      check("data pins", 24'(sg ? (p[9:2] & msk(w)) : 8'h00), 24'(o_seg_pins));
    end
  endtask

  // status word write, then random requests against it
  task automatic grants(input logic en, input logic [3:0] lv);
    logic [3:0] q;
    logic [3:0] rl;
    wr(SFR_PSW, {lv, en, 11'h000});
    tick(2);
    #1;
    check("enable", 24'(en), 24'(o_global_irq_enable));
    check("level", 24'(lv), 24'(o_cpu_priority_level));
    repeat (10) begin
      q = 4'($urandom);
      rl = q[3] ? lv : 4'($urandom);
      tick(1);
      {i_irq_req, i_nmi_req, i_irq_req_level} <= {q[0], q[1] & q[2], rl};
      tick(1);
      #1;
      check("grant", 24'((q[1] & q[2]) | (en & q[0] & (rl > lv))), 24'(o_irq_grant));
    end
    tick(1);
    {i_irq_req, i_nmi_req} <= 2'b00;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {i_clk, i_rst, i_segmented, i_code_ext, tb_start, run} = 6'b011100;
    {i_branch, i_far_jump, i_far_pop, i_irq_accept, i_trap_exec, i_sfr_wr} = '0;
    {i_irq_req, i_nmi_req, i_data_valid} = '0;
    {i_segment_width_setting, i_accept_level, i_irq_req_level} = 12'h870;
    {i_branch_ofs, i_vector_ofs, i_sfr_wdata, i_far_target, i_pop_target} = '0;
    i_sfr_sel = SFR_DATA_PAGE_SELECT_0;
    i_data_req = '0;
    pg = {10'h003, 10'h002, 10'h001, 10'h000};
    err_count = 0;
    num_checks = 0;
    void'($urandom(963));
    tick(6);
    i_rst <= 1'b0;
    tick(2);
    #1;
    check("reset enable", 24'h000000, 24'(o_global_irq_enable));
    check("reset level", 24'h000000, 24'(o_cpu_priority_level));
    check("reset code", 24'h000000, o_code_addr);
    for (int i = 0; i < 4; i++) begin
      rd(sfr_sel_t'(i), 16'(i), "page reset");
    end
    rd(SFR_CSP, 16'h0000, "segment reset");
    for (int i = 0; i < 4; i++) begin
      dacc('{16'(i * 16'h4000 + 16'h1235), 24'h0, 1'b0, 1'b0, 1'b1}, 1'b1, 4'h8);
    end
    ctl(0, '{8'hA5, 16'h1230}, 24'hA51230, "far jump");
    for (int w = 0; w <= 8; w++) begin
      tick(1);
      i_segment_width_setting <= 4'(w);
      tick(2);
      #1;
      check("code pins", 24'(8'hA5 & msk(4'(w))), 24'(o_seg_pins));
    end
    wr(SFR_CSP, 16'h0011);
    rd(SFR_CSP, 16'h00A5, "segment read only");
    ctl(2, '{8'h00, 16'h7FFE}, 24'hA57FFE, "branch");
    ctl(1, '{8'h3C, 16'hFFF0}, 24'h3CFFF0, "far pop");
    b0 = bytes;
    tick(1);
    run <= 1'b1;
    tick(20);
    run <= 1'b0;
    tick(5);
    #1;
    b0 = 16'hFFF0 + bytes - b0;
    check("fetch advance", {8'h3C, b0}, o_code_addr);
    tick(1);
    i_segmented <= 1'b0;
    tick(3);
    #1;
    check("flat code", {8'h00, b0}, o_code_addr);
    check("flat pins", 24'h000000, 24'(o_seg_pins));
    tick(1);
    i_segmented <= 1'b1;
    ctl(3, '{8'h77, 16'h0040}, 24'h000040, "irq entry");
    check("irq level", 24'h000007, 24'(o_cpu_priority_level));
    ctl(0, '{8'h05, 16'h1234}, 24'h051234, "far call");
    ctl(4, '{8'h99, 16'h0080}, 24'h000080, "trap entry");
    grants(1'b0, 4'h0);
    grants(1'b1, 4'h0);
    grants(1'b1, 4'h7);
    grants(1'b1, 4'hF);
    wr(SFR_DATA_PAGE_SELECT_1, 16'hFEA5);
    rd(SFR_DATA_PAGE_SELECT_1, 16'h02A5, "page write");
    r = '{16'h4ABC, 24'h0, 1'b0, 1'b0, 1'b0};
    dacc(r, 1'b1, 4'h8);
    step();
    dacc(r, 1'b1, 4'h8);
    step();
    pg[1] = 10'h2A5;
    dacc(r, 1'b1, 4'h8);
    for (int i = 0; i < 24; i++) begin
      if (i % 6 == 0) begin
        k = (i == 0) ? 0 : $urandom_range(0, 3);
        v = 16'($urandom);
        wr(sfr_sel_t'(k), v);
        tb_start <= 1'b1; // instruction starts right behind the write
        tick(1);
        tb_start <= 1'b0;
        step();
        pg[k] = v[9:0];
      end
      r = '{16'($urandom), 24'($urandom), $urandom_range(0, 3) == 0,
            $urandom_range(0, 3) == 0, 1'($urandom)};
      dacc(r, 1'($urandom), 4'($urandom_range(0, 8)));
    end
    complete_run();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #(25 * 20000);
    err_count++;
    complete_run();
  end
endmodule
